// ==== rtl/iefc_consts.svh ====
// offsets, field positions and reset values of the interrupt front-end
`ifndef IEFC_CONSTS_SVH
`define IEFC_CONSTS_SVH
// word indexes on the avalon address
`define IEFC_OFS_EDGE 4'h0
`define IEFC_OFS_EN1 4'h1
`define IEFC_OFS_EN2 4'h2
`define IEFC_OFS_REQ1 4'h3
`define IEFC_OFS_MODE 4'h4
`define IEFC_OFS_PEND 4'h5
// edge select bits
`define IEFC_EDGE_PIN4 4
`define IEFC_EDGE_PIN3 3
`define IEFC_EDGE_PIN1 1
`define IEFC_EDGE_PIN0 0
`define IEFC_EDGE_WMASK 8'h1B
`define IEFC_EDGE_ONES 8'hE0
// first enable register
`define IEFC_EN1_TIMER_A 7
`define IEFC_EN1_WAKEUP 5
`define IEFC_EN1_PIN4 4
`define IEFC_EN1_PIN3 3
`define IEFC_EN1_COUNTER 2
`define IEFC_EN1_PIN1 1
`define IEFC_EN1_PIN0 0
`define IEFC_EN1_WMASK 8'hBF
// second enable register
`define IEFC_EN2_DT 7
`define IEFC_EN2_CONV 6
`define IEFC_EN2_TG 4
`define IEFC_EN2_TFH 3
`define IEFC_EN2_TFL 2
`define IEFC_EN2_TC 1
`define IEFC_EN2_AEC 0
`define IEFC_EN2_WMASK 8'hDF
// first request register
`define IEFC_REQ_TIMER_A 7
`define IEFC_REQ_PIN4 4
`define IEFC_REQ_PIN3 3
`define IEFC_REQ_COUNTER 2
`define IEFC_REQ_PIN1 1
`define IEFC_REQ_PIN0 0
`define IEFC_REQ_FMASK 8'h9F
`define IEFC_REQ_ONES 8'h20
// mode register: bits 4..0 pin used as interrupt input, bits 7..6 counter sense
`define IEFC_MODE_SENSE_HI 7
`define IEFC_MODE_SENSE_LO 6
`define IEFC_MODE_WMASK 8'hDF
// reset values
`define IEFC_RST_BYTE 8'h00
`define IEFC_RST_WORD 32'h0000_0000
`endif

// ==== rtl/iefc_pkg.sv ====
// types of the interrupt front-end
package iefc_pkg;
   // sense choice for the event counter request pin
   typedef enum logic [1:0] {
      IEFC_SENSE_FALL = 2'b00,
      IEFC_SENSE_RISE = 2'b01,
      IEFC_SENSE_BOTH = 2'b10,
      IEFC_SENSE_NONE = 2'b11
   } iefc_sense_t;
   // external request and shared pin levels
   typedef struct packed {
      logic pin4;
      logic pin3;
      logic counter_pin;
      logic pin1;
      logic pin0;
      logic converter_trigger_pin;
      logic timer_f_event_pin;
      logic timer_c_event_pin;
   } iefc_pins_t;
   // request levels of peripheral sources flagged elsewhere
   typedef struct packed {
      logic direct_transfer;
      logic converter;
      logic timer_g;
      logic timer_f_high;
      logic timer_f_low;
      logic timer_c;
      logic event_counter;
      logic wakeup;
   } iefc_periph_t;
   // gated requests towards the cpu
   typedef struct packed {
      logic direct_transfer;
      logic converter;
      logic timer_g;
      logic timer_f_high;
      logic timer_f_low;
      logic timer_c;
      logic event_counter;
      logic timer_a;
      logic wakeup;
      logic pin4;
      logic pin3;
      logic counter_pin;
      logic pin1;
      logic pin0;
   } iefc_req_t;
   // edge pulses handed to shared-pin peripherals
   typedef struct packed {
      logic converter_trigger;
      logic timer_f_event;
      logic timer_c_event;
   } iefc_evt_t;
   // whole state of the block
   typedef struct packed {
      logic [7:0] edge_reg;
      logic [7:0] en1_reg;
      logic [7:0] en2_reg;
      logic [7:0] flags_reg;
      logic [7:0] mode_reg;
      iefc_pins_t prev_reg;
      iefc_evt_t evt_reg;
      iefc_req_t req_reg;
      logic any_reg;
      logic waitreq_reg;
      logic [31:0] rdata_reg;
   } iefc_state_t;
endpackage

// ==== rtl/iefc_top.sv ====
// interrupt front-end: edge select, source enables and first request flags
`timescale 1ns/1ps
`include "iefc_consts.svh"

// Function
// - bit 4 senses pin4 and converter trigger
// - bit 3 senses pin3 and timer F pin
// - bit 1 senses pin1 and timer C pin
// - bit 0 senses pin0 only
// - enable bit 7 gates timer A overflow
// - enable bit 5 gates all wakeup pins
// - enable bits 4,3 gate pins 4,3
// - enable bit 2 gates counter request pin
// - enable bits 1,0 gate pins 1,0
// - enable-two bit 7 gates direct transfer
// - enable-two bit 6 gates converter end
// - enable-two bit 4 gates timer G
// - enable-two bit 3 gates timer F high
// - enable-two bit 2 gates timer F low
// - enable-two bit 1 gates timer C
// - enable-two bit 0 gates event counter
// - flags stay set, cleared by writing zero
// - timer A overflow sets flag bit 7
// - selected edge sets flag regardless of enable
// - global mask blocks acceptance, not flag setting
module iefc_top
   import iefc_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // avalon-mm slave
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // pins and peripheral events
   input wire iefc_pins_t pins,
   input wire logic timer_a_ovf,
   input wire iefc_periph_t periph_req,
   // cpu side
   input wire logic cpu_int_mask,
   output iefc_req_t cpu_req,
   output logic cpu_int_pending,
   // shared pin edge pulses
   output iefc_evt_t pin_evt
);

   // current and next state
   iefc_state_t s_reg;
   iefc_state_t s_next;

   // edge detector: one selects rising, zero falling
   function automatic logic edge_hit(input logic prev, input logic now, input logic rise);
      edge_hit = rise ? (~prev & now) : (prev & ~now);
   endfunction

   // sticky flag: hardware set beats a software clear
   function automatic logic flag_upd(input logic cur, input logic clr, input logic set);
      flag_upd = (cur & ~clr) | set;
   endfunction

   // merge write data under a writable-bit mask
   function automatic logic [7:0] wr_byte(input logic [7:0] cur, input logic [7:0] wd,
                                          input logic [7:0] wmask);
      wr_byte = (cur & ~wmask) | (wd & wmask);
   endfunction

   // local decode helpers
   logic bus_acc;      // request seen, answer pending
   logic wr_take;      // write takes effect this edge
   logic lane0;        // low byte enabled
   logic hit_pin4;     // selected edge on pin4
   logic hit_pin3;     // selected edge on pin3
   logic hit_pin1;     // selected edge on pin1
   logic hit_pin0;     // selected edge on pin0
   logic hit_cnt;      // selected edge on counter pin
   logic [7:0] flag_set; // set terms for request flags
   logic [7:0] flag_clr; // clear terms for request flags
   logic [7:0] flags_v;  // flags after update
   logic [7:0] rd_byte;  // decoded read byte
   iefc_sense_t cnt_sense; // counter pin sense choice
   iefc_req_t req_v;       // gated requests

   // next-state logic
   always_comb
   begin
      s_next = s_reg;
      // bus handshake: answer one cycle after the request is seen
      bus_acc = (avs_read | avs_write) & s_reg.waitreq_reg;
      wr_take = avs_write & ~s_reg.waitreq_reg;
      lane0 = avs_byteenable[0];
      cnt_sense = iefc_sense_t'(s_reg.mode_reg[`IEFC_MODE_SENSE_HI:`IEFC_MODE_SENSE_LO]);

      // edge detection on request pins
      hit_pin4 = edge_hit(s_reg.prev_reg.pin4, pins.pin4,
                          s_reg.edge_reg[`IEFC_EDGE_PIN4]);
      hit_pin3 = edge_hit(s_reg.prev_reg.pin3, pins.pin3,
                          s_reg.edge_reg[`IEFC_EDGE_PIN3]);
      hit_pin1 = edge_hit(s_reg.prev_reg.pin1, pins.pin1,
                          s_reg.edge_reg[`IEFC_EDGE_PIN1]);
      hit_pin0 = edge_hit(s_reg.prev_reg.pin0, pins.pin0,
                          s_reg.edge_reg[`IEFC_EDGE_PIN0]);
      // counter pin: fall, rise or both
      case (cnt_sense)
         IEFC_SENSE_FALL:
         begin
            hit_cnt = s_reg.prev_reg.counter_pin & ~pins.counter_pin;
         end
         IEFC_SENSE_RISE:
         begin
            hit_cnt = ~s_reg.prev_reg.counter_pin & pins.counter_pin;
         end
         IEFC_SENSE_BOTH:
         begin
            hit_cnt = s_reg.prev_reg.counter_pin ^ pins.counter_pin;
         end
         default:
         begin
            hit_cnt = 1'b0;
         end
      endcase

      // shared pins follow the same edge bits
      s_next.evt_reg.converter_trigger = edge_hit(s_reg.prev_reg.converter_trigger_pin,
         pins.converter_trigger_pin, s_reg.edge_reg[`IEFC_EDGE_PIN4]);
      s_next.evt_reg.timer_f_event = edge_hit(s_reg.prev_reg.timer_f_event_pin,
         pins.timer_f_event_pin, s_reg.edge_reg[`IEFC_EDGE_PIN3]);
      s_next.evt_reg.timer_c_event = edge_hit(s_reg.prev_reg.timer_c_event_pin,
         pins.timer_c_event_pin, s_reg.edge_reg[`IEFC_EDGE_PIN1]);
      s_next.prev_reg = pins;

      // flag set terms, only for pins used as interrupt inputs, ignoring enables
      flag_set = 8'h00;
      flag_set[`IEFC_REQ_TIMER_A] = timer_a_ovf;
      flag_set[`IEFC_REQ_PIN4] = hit_pin4 & s_reg.mode_reg[`IEFC_REQ_PIN4];
      flag_set[`IEFC_REQ_PIN3] = hit_pin3 & s_reg.mode_reg[`IEFC_REQ_PIN3];
      flag_set[`IEFC_REQ_COUNTER] = hit_cnt & s_reg.mode_reg[`IEFC_REQ_COUNTER];
      flag_set[`IEFC_REQ_PIN1] = hit_pin1 & s_reg.mode_reg[`IEFC_REQ_PIN1];
      flag_set[`IEFC_REQ_PIN0] = hit_pin0 & s_reg.mode_reg[`IEFC_REQ_PIN0];

      // clear terms: a written zero clears, a written one is ignored
      flag_clr = 8'h00;
      if (wr_take && lane0 && avs_address == `IEFC_OFS_REQ1)
      begin
         flag_clr = ~avs_writedata[7:0] & `IEFC_REQ_FMASK;
      end
      flags_v = 8'h00;
      for (int i = 0; i < 8; i++)
      begin
         flags_v[i] = flag_upd(s_reg.flags_reg[i], flag_clr[i], flag_set[i]);
      end
      // reserved flag positions never hold a one
      s_next.flags_reg = flags_v & `IEFC_REQ_FMASK;

      // register writes, reserved bits never stored
      if (wr_take && lane0)
      begin
         if (avs_address == `IEFC_OFS_EDGE)
         begin
            s_next.edge_reg = wr_byte(s_reg.edge_reg, avs_writedata[7:0],
                                      `IEFC_EDGE_WMASK);
         end
         else if (avs_address == `IEFC_OFS_EN1)
         begin
            s_next.en1_reg = wr_byte(s_reg.en1_reg, avs_writedata[7:0],
                                     `IEFC_EN1_WMASK);
         end
         else if (avs_address == `IEFC_OFS_EN2)
         begin
            s_next.en2_reg = wr_byte(s_reg.en2_reg, avs_writedata[7:0],
                                     `IEFC_EN2_WMASK);
         end
         else if (avs_address == `IEFC_OFS_MODE)
         begin
            s_next.mode_reg = wr_byte(s_reg.mode_reg, avs_writedata[7:0],
                                      `IEFC_MODE_WMASK);
         end
      end

      // gate each source by its enable bit
      req_v.timer_a = s_reg.flags_reg[`IEFC_REQ_TIMER_A] &
                      s_reg.en1_reg[`IEFC_EN1_TIMER_A];
      req_v.wakeup = periph_req.wakeup & s_reg.en1_reg[`IEFC_EN1_WAKEUP];
      req_v.pin4 = s_reg.flags_reg[`IEFC_REQ_PIN4] & s_reg.en1_reg[`IEFC_EN1_PIN4];
      req_v.pin3 = s_reg.flags_reg[`IEFC_REQ_PIN3] & s_reg.en1_reg[`IEFC_EN1_PIN3];
      req_v.counter_pin = s_reg.flags_reg[`IEFC_REQ_COUNTER] &
                          s_reg.en1_reg[`IEFC_EN1_COUNTER];
      req_v.pin1 = s_reg.flags_reg[`IEFC_REQ_PIN1] & s_reg.en1_reg[`IEFC_EN1_PIN1];
      req_v.pin0 = s_reg.flags_reg[`IEFC_REQ_PIN0] & s_reg.en1_reg[`IEFC_EN1_PIN0];
      req_v.direct_transfer = periph_req.direct_transfer & s_reg.en2_reg[`IEFC_EN2_DT];
      req_v.converter = periph_req.converter & s_reg.en2_reg[`IEFC_EN2_CONV];
      req_v.timer_g = periph_req.timer_g & s_reg.en2_reg[`IEFC_EN2_TG];
      req_v.timer_f_high = periph_req.timer_f_high & s_reg.en2_reg[`IEFC_EN2_TFH];
      req_v.timer_f_low = periph_req.timer_f_low & s_reg.en2_reg[`IEFC_EN2_TFL];
      req_v.timer_c = periph_req.timer_c & s_reg.en2_reg[`IEFC_EN2_TC];
      req_v.event_counter = periph_req.event_counter & s_reg.en2_reg[`IEFC_EN2_AEC];
      s_next.req_reg = req_v;
      // masked cpu sees no pending request, flags keep setting
      s_next.any_reg = (|req_v) & ~cpu_int_mask;

      // read decode, reserved bits as fixed
      if (avs_address == `IEFC_OFS_EDGE)
      begin
         rd_byte = (s_reg.edge_reg & `IEFC_EDGE_WMASK) | `IEFC_EDGE_ONES;
      end
      else if (avs_address == `IEFC_OFS_EN1)
      begin
         rd_byte = s_reg.en1_reg;
      end
      else if (avs_address == `IEFC_OFS_EN2)
      begin
         rd_byte = s_reg.en2_reg;
      end
      else if (avs_address == `IEFC_OFS_REQ1)
      begin
         rd_byte = s_reg.flags_reg | `IEFC_REQ_ONES;
      end
      else if (avs_address == `IEFC_OFS_MODE)
      begin
         rd_byte = s_reg.mode_reg;
      end
      else if (avs_address == `IEFC_OFS_PEND)
      begin
         rd_byte = {s_reg.req_reg.timer_a, s_reg.any_reg, s_reg.req_reg.wakeup,
                    s_reg.req_reg.pin4, s_reg.req_reg.pin3, s_reg.req_reg.counter_pin,
                    s_reg.req_reg.pin1, s_reg.req_reg.pin0};
      end
      else
      begin
         rd_byte = `IEFC_RST_BYTE; // unmapped reads zero
      end

      // capture read data as the answer is raised
      if (bus_acc && avs_read)
      begin
         s_next.rdata_reg = {24'h000000, rd_byte};
      end
      s_next.waitreq_reg = ~bus_acc;
   end

   // state register, synchronous reset
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         s_reg <= '0;
         s_reg.edge_reg <= `IEFC_RST_BYTE;
         s_reg.en1_reg <= `IEFC_RST_BYTE;
         s_reg.en2_reg <= `IEFC_RST_BYTE;
         s_reg.flags_reg <= `IEFC_RST_BYTE;
         s_reg.rdata_reg <= `IEFC_RST_WORD;
         // request pins idle high, so no false edge follows reset
         s_reg.prev_reg <= '1;
         s_reg.waitreq_reg <= 1'b1;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   // outputs straight from flops
   assign avs_readdata = s_reg.rdata_reg;
   assign avs_waitrequest = s_reg.waitreq_reg;
   assign cpu_req = s_reg.req_reg;
   assign cpu_int_pending = s_reg.any_reg;
   assign pin_evt = s_reg.evt_reg;

endmodule

// ==== verif/iefc_asserts.sv ====
// port checker of the interrupt front-end
`timescale 1ns/1ps
`include "iefc_consts.svh"
module iefc_asserts
   import iefc_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // register bus
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // events and cpu side
   input wire iefc_pins_t pins,
   input wire logic timer_a_ovf,
   input wire iefc_periph_t periph_req,
   input wire logic cpu_int_mask,
   input wire iefc_req_t cpu_req,
   input wire logic cpu_int_pending,
   input wire iefc_evt_t pin_evt
);
   logic [7:0] e0_m, e1_m, e2_m; // shadow registers
   logic [2:0] was_m; // shared pins one edge ago
   iefc_evt_t evt_m; // expected edge pulses
   logic [1:0] live_m; // edges since reset
   wire fire = avs_write && !avs_waitrequest && avs_byteenable[0];
   wire rdy = avs_read && !avs_waitrequest;
   wire [7:0] wd = avs_writedata[7:0];
   wire [2:0] now = {pins.converter_trigger_pin, pins.timer_f_event_pin, pins.timer_c_event_pin};
   wire [2:0] sel = {e0_m[4], e0_m[3], e0_m[1]};
   wire [6:0] gate2 = periph_req[7:1] & {e2_m[7:6], e2_m[4:0]};
   wire wake_g = periph_req.wakeup & e1_m[5];
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // shadows follow accepted writes
   always_ff @(posedge clock)
   begin
      was_m <= now;
      if (rst)
      begin
         e0_m <= 8'h00;
         e1_m <= 8'h00;
         e2_m <= 8'h00;
         evt_m <= '0;
         live_m <= 2'h0;
      end
      else
      begin
         if (fire && avs_address == `IEFC_OFS_EDGE) e0_m <= wd & `IEFC_EDGE_WMASK;
         if (fire && avs_address == `IEFC_OFS_EN1) e1_m <= wd & `IEFC_EN1_WMASK;
         if (fire && avs_address == `IEFC_OFS_EN2) e2_m <= wd & `IEFC_EN2_WMASK;
         evt_m <= (sel & now & ~was_m) | (~sel & ~now & was_m);
         if (live_m != 2'h3) live_m <= live_m + 2'h1;
      end
   end
   // handshake steps
   sequence s_ask;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_ans;
      ##[0:2] !avs_waitrequest;
   endsequence
   a_bus_answer: assert property (s_ask |-> s_ans)
      else $error("bus request not answered");
   a_wait_pulse: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
      else $error("waitrequest low too long");
   a_edge_readback: assert property (rdy && avs_address == `IEFC_OFS_EDGE |->
      avs_readdata == {24'h0, e0_m | `IEFC_EDGE_ONES}) else $error("edge select readback");
   a_en1_readback: assert property (rdy && avs_address == `IEFC_OFS_EN1 |->
      avs_readdata == {24'h0, e1_m}) else $error("enable one readback");
   a_en2_readback: assert property (rdy && avs_address == `IEFC_OFS_EN2 |->
      avs_readdata == {24'h0, e2_m}) else $error("enable two readback");
   a_flag_fixed: assert property (rdy && avs_address == `IEFC_OFS_REQ1 |->
      avs_readdata[31:5] == 27'h1 || avs_readdata[31:5] == 27'h5) else $error("flag fixed bits");
   a_en2_gate: assert property ($stable(e2_m) |-> cpu_req[13:7] == $past(gate2))
      else $error("peripheral gating");
   a_wake_gate: assert property ($stable(e1_m) |-> cpu_req.wakeup == $past(wake_g))
      else $error("wakeup gating");
   a_evt_match: assert property (live_m == 2'h3 |-> pin_evt == evt_m)
      else $error("shared pin pulse");
   a_mask_blocks: assert property (cpu_int_mask && $past(cpu_int_mask) |-> !cpu_int_pending)
      else $error("pending while masked");
   a_pend_follow: assert property (!cpu_int_mask && !$past(cpu_int_mask) |->
      cpu_int_pending == (cpu_req != '0)) else $error("pending mismatch");
endmodule

// ==== verif/iefc_far_model.sv ====
// far side: request pins, peripheral events and cpu mask
`timescale 1ns/1ps
module iefc_far_model
   import iefc_pkg::*;
(
   // clock
   input wire logic clock,
   // towards the block
   output iefc_pins_t pins,
   output logic timer_a_ovf,
   output iefc_periph_t periph_req,
   output logic cpu_int_mask
);
   // pins rest high, nothing requested
   initial
   begin
      pins = 8'hFF;
      timer_a_ovf = 1'b0;
      periph_req = '0;
      cpu_int_mask = 1'b0;
   end
   // pin levels change just after an edge
   task set_pins(input iefc_pins_t v);
      @(posedge clock);
      pins <= v;
   endtask
   // one-cycle timer a overflow
   task pulse_ovf;
      @(posedge clock);
      timer_a_ovf <= 1'b1;
      @(posedge clock);
      timer_a_ovf <= 1'b0;
   endtask
   // peripheral levels and global mask
   task set_src(input iefc_periph_t v, input logic m);
      @(posedge clock);
      periph_req <= v;
      cpu_int_mask <= m;
   endtask
endmodule

// ==== verif/iefc_top_tb.sv ====
// self-checking bench of the interrupt front-end
`timescale 1ns/1ps
`include "iefc_consts.svh"
module iefc_top_tb
   import iefc_pkg::*;
;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   iefc_pins_t pins;
   logic timer_a_ovf;
   iefc_periph_t periph_req;
   logic cpu_int_mask;
   iefc_req_t cpu_req;
   logic cpu_int_pending;
   iefc_evt_t pin_evt;
   int err_count = 0;
   int cmp_count = 0;
   int cycles = 0;
   logic [7:0] rd; // last read byte
   always #10 clock = ~clock;
   iefc_top iefc_top_inst (.clock(clock), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .pins(pins), .timer_a_ovf(timer_a_ovf),
      .periph_req(periph_req), .cpu_int_mask(cpu_int_mask), .cpu_req(cpu_req),
      .cpu_int_pending(cpu_int_pending), .pin_evt(pin_evt));
   iefc_far_model iefc_far_model_inst (.clock(clock), .pins(pins), .timer_a_ovf(timer_a_ovf),
      .periph_req(periph_req), .cpu_int_mask(cpu_int_mask));
   // compare and count
   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask
   // verdict and end of run
   task conclude;
      $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // one avalon transfer, held until waitrequest low
   task bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_byteenable <= 4'hF;
      avs_write <= wr;
      avs_read <= ~wr;
      @(posedge clock);
      // only the hang guard ends a wait that never gets its answer
      while (avs_waitrequest !== 1'b0)
      begin
         @(posedge clock);
      end
      rd = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   // settle after some edges
   task wait_c(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // reset values and unmapped reads
   task t_reset;
      bus(0, `IEFC_OFS_EDGE, 8'h00);
      chk("edge reset", rd, 8'hE0);
      bus(0, `IEFC_OFS_EN1, 8'h00);
      chk("en1 reset", rd, 8'h00);
      bus(0, `IEFC_OFS_EN2, 8'h00);
      chk("en2 reset", rd, 8'h00);
      bus(0, `IEFC_OFS_REQ1, 8'h00);
      chk("flags reset", rd, 8'h20);
      bus(0, 4'hF, 8'h00);
      chk("unmapped", rd, 8'h00);
   endtask
   // writable fields, reserved bits written zero
   task t_regs;
      bus(1, `IEFC_OFS_EN1, 8'hBF);
      bus(1, `IEFC_OFS_EN2, 8'hDF);
      bus(1, 4'h9, 8'h00);
      bus(0, `IEFC_OFS_EN1, 8'h00);
      chk("en1 all", rd, 8'hBF);
      bus(0, `IEFC_OFS_EN2, 8'h00);
      chk("en2 all", rd, 8'hDF);
      bus(1, `IEFC_OFS_EN1, 8'h00);
      bus(1, `IEFC_OFS_EN2, 8'h00);
   endtask
   // both edge-select senses on pins 0, 1, 3, 4 and their shared pins
   task t_pins;
      int no[4] = '{0, 1, 3, 4};
      logic [7:0] pm[4] = '{8'h08, 8'h11, 8'h42, 8'h84};
      logic [7:0] v, b;
      v = 8'hFF;
      bus(1, `IEFC_OFS_MODE, 8'h1F);
      for (int i = 0; i < 4; i++)
         for (int s = 0; s < 2; s++)
         begin
            b = 8'h01 << no[i];
            bus(1, `IEFC_OFS_EDGE, s ? b : 8'h00);
            bus(1, `IEFC_OFS_EN1, s ? b : 8'h00);
            v = s ? v & ~pm[i] : v | pm[i];
            iefc_far_model_inst.set_pins(v);
            wait_c(3);
            bus(1, `IEFC_OFS_REQ1, ~b & 8'hBF);
            v = v ^ pm[i];
            iefc_far_model_inst.set_pins(v);
            wait_c(1);
            chk("shared pulse", pin_evt, pm[i][2:0]);
            wait_c(2);
            chk("pin request", cpu_req[no[i]], s);
            chk("pending", cpu_int_pending, s);
            bus(1, `IEFC_OFS_REQ1, 8'h9F);
            bus(0, `IEFC_OFS_REQ1, 8'h00);
            chk("pin flag", rd[no[i]], 1'b1);
            bus(1, `IEFC_OFS_REQ1, ~b & 8'hBF);
            wait_c(2);
            chk("cleared request", cpu_req[no[i]], 1'b0);
            v = v ^ pm[i];
            iefc_far_model_inst.set_pins(v);
            wait_c(3);
            bus(0, `IEFC_OFS_REQ1, 8'h00);
            chk("other edge", rd[no[i]], 1'b0);
         end
      bus(1, `IEFC_OFS_EN1, 8'h00);
   endtask
   // counter pin under each sense choice: fall, rise, both, none
   task t_counter;
      logic [1:0] hit[4] = '{2'b01, 2'b10, 2'b11, 2'b00};
      bus(1, `IEFC_OFS_EN1, 8'h04);
      for (int m = 0; m < 4; m++)
      begin
         bus(1, `IEFC_OFS_MODE, {m[1:0], 6'h1F});
         for (int t = 0; t < 2; t++)
         begin
            iefc_far_model_inst.set_pins(pins ^ 8'h20);
            wait_c(3);
            chk("counter request", cpu_req.counter_pin, hit[m][t]);
            bus(0, `IEFC_OFS_PEND, 8'h00);
            chk("pending reg", rd[2], hit[m][t]);
            bus(0, `IEFC_OFS_REQ1, 8'h00);
            chk("counter flag", rd[2], hit[m][t]);
            bus(1, `IEFC_OFS_REQ1, 8'hBB);
         end
      end
      bus(1, `IEFC_OFS_EN1, 8'h00);
   endtask
   // overflow flag, enabled and disabled
   task t_timer_a;
      for (int s = 1; s >= 0; s--)
      begin
         bus(1, `IEFC_OFS_EN1, s ? 8'h80 : 8'h00);
         iefc_far_model_inst.pulse_ovf();
         wait_c(3);
         chk("timer a request", cpu_req.timer_a, s);
         bus(0, `IEFC_OFS_REQ1, 8'h00);
         chk("timer a flag", rd[7], 1'b1);
         bus(1, `IEFC_OFS_REQ1, 8'h3F);
         bus(0, `IEFC_OFS_REQ1, 8'h00);
         chk("timer a clear", rd[7], 1'b0);
      end
   endtask
   // each peripheral source under two enable patterns
   task t_periph;
      logic [7:0] e1[2] = '{8'h20, 8'h00};
      logic [7:0] e2[2] = '{8'h95, 8'h4A};
      logic [7:0] p;
      for (int k = 0; k < 2; k++)
      begin
         bus(1, `IEFC_OFS_EN1, e1[k]);
         bus(1, `IEFC_OFS_EN2, e2[k]);
         for (int j = 0; j < 8; j++)
         begin
            p = 8'h01 << j;
            iefc_far_model_inst.set_src(p, 1'b0);
            wait_c(3);
            chk("source gate", cpu_req, {p[7:1] & {e2[k][7:6], e2[k][4:0]}, 1'b0,
               p[0] & e1[k][5], 5'h00});
         end
      end
   endtask
   // global mask holds acceptance but not flags
   task t_mask;
      bus(1, `IEFC_OFS_EN2, 8'h80);
      iefc_far_model_inst.set_src(8'h80, 1'b1);
      iefc_far_model_inst.pulse_ovf();
      wait_c(3);
      chk("masked pending", cpu_int_pending, 1'b0);
      bus(0, `IEFC_OFS_REQ1, 8'h00);
      chk("masked flag", rd[7], 1'b1);
      iefc_far_model_inst.set_src(8'h80, 1'b0);
      wait_c(3);
      chk("unmasked pending", cpu_int_pending, 1'b1);
   endtask
   // main sequence
   initial
   begin
      repeat (5) @(posedge clock);
      rst <= 1'b0;
      t_reset();
      t_regs();
      t_pins();
      t_counter();
      t_timer_a();
      t_periph();
      t_mask();
      conclude();
   end
   // hang guard
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_count++;
         conclude();
      end
   end
endmodule
bind iefc_top iefc_asserts iefc_asserts_inst (.clock(clock), .rst(rst),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pins(pins),
   .timer_a_ovf(timer_a_ovf), .periph_req(periph_req), .cpu_int_mask(cpu_int_mask),
   .cpu_req(cpu_req), .cpu_int_pending(cpu_int_pending), .pin_evt(pin_evt));
